/* File: dv/lse_slave_model.sv */
// slave nodes answering the executor's slots
`timescale 1ns/1ns
module lse_slave_model (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // slot view
  input  wire logic        i_hdr_req,
  input  wire logic [1:0]  i_kind,
  input  wire logic [2:0]  i_frame,
  // data update by the bench
  input  wire logic        i_set,
  input  wire logic [7:0]  i_set_mask,
  // collision report
  output logic             o_collision
);
  logic [7:0] pend;
  logic [1:0] dly;

  always @(posedge i_sys_clk) begin
    o_collision <= dly[1];
    dly <= {dly[0], 1'b0};
    if (i_reset) begin
      pend <= 8'h00;
      dly <= 2'h0;
      o_collision <= 1'b0;
    end else begin
      if (i_set)
        pend <= pend | i_set_mask;
      if (i_hdr_req && i_kind == 2'h2) begin
        // two answers collide, one answer clears the update
        if ($countones(pend) > 1)
          dly <= 2'h1;
        else
          pend <= 8'h00;
      end
      if (i_hdr_req && i_kind == 2'h0)
        pend[i_frame] <= 1'b0;
    end
  end
endmodule // lse_slave_model

/* File: dv/testbench.sv */
// self-checking bench of the schedule entry executor
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module testbench;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [5:0]  i_addr = 6'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        i_collision;
  logic        o_hdr_req;
  logic        o_res_req;
  logic        o_irq;
  logic [5:0]  o_hdr_id;
  logic [2:0]  o_tx_frame;
  logic [63:0] o_tx_data;
  logic        set_p = 1'b0;
  logic [7:0]  set_m = 8'h00;
  lse_pkg::lse_kind_t o_hdr_kind;
  int n_errors = 0;
  int checks_done = 0;
  int n_hdr = 0;
  int n_res = 0;
  int cyc = 0;
  logic [1:0]  hk[32];
  logic [5:0]  hid[32];
  logic [2:0]  hfr[32];
  logic [63:0] hdt[32];
  int ht[32];
  int sq[9] = '{0, 1, 2, 3, 4, 5, 3, 4, 5};
  int ek[6] = '{0, 1, 3, 2, 0, 0};
  int eid[6] = '{'h11, 'h12, 0, 'h2a, 'h10, 'h13};
  int efr[6] = '{1, 2, 0, 0, 0, 3};
  int edl[6] = '{5, 5, 2, 6, 5, 3};

  lse_sched_exec lse_sched_exec_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_collision(i_collision), .o_hdr_req(o_hdr_req),
    .o_hdr_kind(o_hdr_kind), .o_hdr_id(o_hdr_id),
    .o_tx_frame(o_tx_frame), .o_tx_data(o_tx_data),
    .o_res_req(o_res_req), .o_irq(o_irq));

  lse_slave_model lse_slave_model_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_hdr_req(o_hdr_req),
    .i_kind(o_hdr_kind), .i_frame(o_tx_frame), .i_set(set_p),
    .i_set_mask(set_m), .o_collision(i_collision));

  always #2 i_sys_clk = ~i_sys_clk;

  // slot monitor
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (o_res_req)
      n_res <= n_res + 1;
    if (o_hdr_req && n_hdr < 32) begin
      hk[n_hdr] <= o_hdr_kind;
      hid[n_hdr] <= o_hdr_id;
      hfr[n_hdr] <= o_tx_frame;
      hdt[n_hdr] <= o_tx_data;
      ht[n_hdr] <= cyc;
      n_hdr <= n_hdr + 1;
    end
  end

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic ent(input logic [3:0] e, input logic [1:0] k,
                     input logic [7:0] m, input logic [5:0] id,
                     input logic [19:0] dl);
    wr(lse_pkg::OFF_ENT_SEL, {28'h0, e});
    wr(lse_pkg::OFF_ENT_CFG, {8'h00, 4'h5, 4'h4, id, m, k});
    wr(lse_pkg::OFF_ENT_DLY, {12'h000, dl});
  endtask

  task automatic wait_hdr(input int n);
    for (int i = 0; i < 600 && n_hdr < n; i++)
      @(posedge i_sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    int e;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd(lse_pkg::OFF_ENT_DLY, d);
    `CHK(d[19:0], lse_pkg::DLY_RST)
    rd(6'h30, d);
    `CHK(d, 32'h0)
    // frame ids 0..3 are 6'h10..6'h13
    wr(lse_pkg::OFF_FRM_ID_LO, 32'h004d2450);
    ent(4'h0, 2'h0, 8'h06, 6'h00, 20'h5);
    ent(4'h1, 2'h1, 8'h0c, 6'h00, 20'h5);
    ent(4'h3, 2'h2, 8'h09, 6'h2a, 20'h6);
    ent(4'h4, 2'h0, 8'h01, 6'h00, 20'h5);
    ent(4'h5, 2'h0, 8'h08, 6'h00, 20'h3);
    ent(4'h2, 2'h3, 8'h00, 6'h00, 20'h0);
    wr(lse_pkg::OFF_RAW_LO, 32'h44332211);
    wr(lse_pkg::OFF_RAW_HI, 32'h88776655);
    wr(lse_pkg::OFF_IRQ_MASK, 32'h1);
    wr(lse_pkg::OFF_FRM_UPD, 32'h0c);
    @(posedge i_sys_clk);
    set_p <= 1'b1;
    set_m <= 8'h09;
    @(posedge i_sys_clk);
    set_p <= 1'b0;
    wr(lse_pkg::OFF_CTRL, 32'h503);
    wait_hdr(9);
    repeat (12) @(posedge i_sys_clk);
    `CHK(n_hdr, 9)
    for (int i = 0; i < 9; i++) begin
      e = sq[i];
      `CHK(hk[i], ek[e][1:0])
      if (e != 2)
        `CHK(hid[i], eid[e][5:0])
      if (ek[e] < 2)
        `CHK(hfr[i], efr[e][2:0])
      if (e == 2)
        `CHK(hdt[i], 64'h8877665544332211)
      if (i > 0)
        `CHK(ht[i] - ht[i-1], edl[sq[i-1]])
    end
    `CHK(n_res, 1)
    `CHK(o_irq, 1'b1)
    rd(lse_pkg::OFF_IRQ_STAT, d);
    `CHK(d[2:0], 3'h7)
    rd(lse_pkg::OFF_FRM_UPD, d);
    `CHK(d[7:0], 8'h08)
    rd(lse_pkg::OFF_CTRL, d);
    `CHK(d[0], 1'b0)
    wr(lse_pkg::OFF_IRQ_STAT, 32'h7);
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK(o_irq, 1'b0)
    // continuous over entries 1..5, sporadic frame 3 still pending
    wr(lse_pkg::OFF_CTRL, 32'h511);
    wait_hdr(15);
    wr(lse_pkg::OFF_CTRL, 32'h0);
    `CHK(hk[9], 2'h1)
    `CHK(hfr[9], 3'h3)
    `CHK(hfr[12], 3'h0)
    `CHK(hfr[13], 3'h3)
    // second sporadic slot is silent but still timed
    `CHK(ht[14] - ht[13], edl[5] + edl[1])
    `CHK(hk[14], 2'h3)
    `CHK(hdt[0], 64'h0)
    tally_and_finish();
  end
endmodule // testbench

/* File: hw/lse_pkg.sv */
// constants, register map and types of the lin schedule entry executor
package lse_pkg;

  // sizes
  localparam int ADDR_W  = 6;
  localparam int NUM_ENT = 16;
  localparam int IDX_W   = 4;
  localparam int NUM_FRM = 8;
  localparam int FIDX_W  = 3;
  localparam int ID_W    = 6;
  localparam int DLY_W   = 20;
  localparam int IRQ_W   = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_FRM_UPD   = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_ENT_SEL   = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_ENT_CFG   = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_ENT_DLY   = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_RAW_LO    = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_RAW_HI    = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_FRM_ID_LO = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_FRM_ID_HI = 6'h2c;

  // control register fields
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_POL   = 1;
  localparam int CTRL_FIRST = 4;
  localparam int CTRL_LAST  = 8;

  // interrupt status bits
  localparam int IRQ_COLL = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_SPOR = 2;

  // reset values
  localparam logic [DLY_W-1:0] DLY_RST  = 20'h00002;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    KIND_UNCOND   = 2'h0,
    KIND_SPORADIC = 2'h1,
    KIND_EVENT    = 2'h2,
    KIND_NODE_CFG = 2'h3
  } lse_kind_t;

  typedef enum logic [1:0] {
    POL_CONT = 2'h0,
    POL_ONCE = 2'h1,
    POL_NULL = 2'h2
  } lse_policy_t;

  typedef enum logic [2:0] {
    FSM_IDLE  = 3'b001,
    FSM_START = 3'b010,
    FSM_WAIT  = 3'b100
  } lse_fsm_t;

  // entry configuration word, kind in the low bits
  typedef struct packed {
    logic [IDX_W-1:0]   res_last;
    logic [IDX_W-1:0]   res_first;
    logic [ID_W-1:0]    event_entry_identifier;
    logic [NUM_FRM-1:0] frame_mask;
    lse_kind_t          kind;
  } lse_ent_cfg_t;

  // byte 0 of the raw bytes sits in bits 7:0 and goes first
  typedef struct packed {
    lse_ent_cfg_t  cfg;
    logic [DLY_W-1:0] delay;
    logic [63:0]   node_cfg_raw_bytes;
  } lse_ent_t;

  typedef struct packed {
    logic [DLY_W-1:0] cnt;
  } lse_tmr_st_t;

endpackage

/* File: hw/lse_sched_exec.sv */
// lin schedule entry executor: register file, slot sequencer
//
// Behaviour
// - unconditional entry transfers exactly its one assigned frame in its slot
// - sporadic entry sends only an updated frame, otherwise nothing
// - among updated sporadic frames the earliest in the list wins
// - updated sporadic frames not chosen stay pending for next execution
// - collision in event-triggered slot requests that entry's resolving table
// - resolving table runs one pass starting in the slot after collision
// - after the resolving pass the schedule resumes at the collision entry
// - node configuration entry holds eight raw bytes in bus order
// - node configuration service runs only for type code 3
// - unconditional entry uses one frame; sporadic and event use one or more
// - one frame may be referenced by several entries and tables
// - every entry has a programmed slot duration, start to next start; a delay below 2 gives a 2-cycle slot
// - continuous policy restarts at first entry after the last
// - a resolving table always runs as a single pass
// - event slot sends entry identifier; slave puts frame identifier first
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module lse_sched_exec (
  // clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_reset,
  // register port
  input  wire logic [lse_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [31:0]                 o_rdata,
  // frame engine
  input  wire logic                        i_collision,
  output logic                             o_hdr_req,
  output lse_pkg::lse_kind_t               o_hdr_kind,
  output logic      [lse_pkg::ID_W-1:0]    o_hdr_id,
  output logic      [lse_pkg::FIDX_W-1:0]  o_tx_frame,
  output logic      [63:0]                 o_tx_data,
  output logic                             o_res_req,
  // interrupt
  output logic                             o_irq
);

  typedef struct packed {
    lse_pkg::lse_fsm_t                                fsm;
    logic [lse_pkg::IDX_W-1:0]                        cur;
    logic [lse_pkg::IDX_W-1:0]                        ret_idx;
    logic [lse_pkg::IDX_W-1:0]                        res_end;
    logic                                             in_res;
    logic                                             coll_seen;
    logic                                             run;
    lse_pkg::lse_policy_t                             table_run_policy;
    logic [lse_pkg::IDX_W-1:0]                        first;
    logic [lse_pkg::IDX_W-1:0]                        last;
    logic [lse_pkg::IRQ_W-1:0]                        irq_stat;
    logic [lse_pkg::IRQ_W-1:0]                        irq_mask;
    logic [lse_pkg::NUM_FRM-1:0]                      pend;
    logic [lse_pkg::IDX_W-1:0]                        sel;
    logic [lse_pkg::NUM_FRM-1:0][lse_pkg::ID_W-1:0]   frm_id;
    lse_pkg::lse_ent_t [lse_pkg::NUM_ENT-1:0]         ent;
    logic                                             hdr_req;
    lse_pkg::lse_kind_t                               hdr_kind;
    logic [lse_pkg::ID_W-1:0]                         hdr_id;
    logic [lse_pkg::FIDX_W-1:0]                       tx_frame;
    logic [63:0]                                      tx_data;
    logic                                             res_req;
    logic                                             irq;
    logic [31:0]                                      rdata;
  } lse_exec_st_t;

  lse_exec_st_t st;
  lse_exec_st_t next_st;

  lse_tmr_if tmr_bus ();

  lse_slot_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .tmr       (tmr_bus.tmr)
  );

  // first set bit of a frame list
  function automatic logic [lse_pkg::FIDX_W-1:0] pick_first(
    input logic [lse_pkg::NUM_FRM-1:0] m
  );
    logic [lse_pkg::FIDX_W-1:0] r;
    r = '0;
    for (int i = lse_pkg::NUM_FRM - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = lse_pkg::FIDX_W'(i);
      end
    end
    return r;
  endfunction

  lse_pkg::lse_ent_t            ent;
  logic [lse_pkg::NUM_FRM-1:0]  spor_hit;
  logic [lse_pkg::FIDX_W-1:0]   spor_pick;
  logic [lse_pkg::FIDX_W-1:0]   unc_pick;
  logic                         coll_now;
  logic                         at_start;
  logic                         slot_end;
  logic [lse_pkg::IRQ_W-1:0]    irq_ev;
  logic [lse_pkg::IRQ_W-1:0]    irq_clr;
  logic [lse_pkg::NUM_FRM-1:0]  pend_set;
  logic [lse_pkg::NUM_FRM-1:0]  pend_clr;

  assign ent       = st.ent[st.cur];
  assign spor_hit  = ent.cfg.frame_mask & st.pend;
  assign spor_pick = pick_first(spor_hit);
  assign unc_pick  = pick_first(ent.cfg.frame_mask);
  assign at_start  = (st.fsm == lse_pkg::FSM_START);
  assign slot_end  = (st.fsm == lse_pkg::FSM_WAIT) && tmr_bus.expire;
  // collision counts only in an event slot of the main table
  assign coll_now  = st.coll_seen
                   | (i_collision && ent.cfg.kind == lse_pkg::KIND_EVENT
                      && !st.in_res);

  // slot timer loaded at each entry start
  assign tmr_bus.load  = at_start;
  assign tmr_bus.value = (ent.delay > 20'h00001)
                       ? ent.delay - 20'h00001 : 20'h00001;

  always_comb begin
    next_st  = st;
    irq_ev   = '0;
    irq_clr  = '0;
    pend_set = '0;
    pend_clr = '0;
    next_st.hdr_req = 1'b0;
    next_st.res_req = 1'b0;
    next_st.rdata   = '0;

    // register writes
    if (i_wr) begin
      unique case (i_addr)
        lse_pkg::OFF_CTRL: begin
          next_st.run              = i_wdata[lse_pkg::CTRL_RUN];
          next_st.table_run_policy =
            lse_pkg::lse_policy_t'(i_wdata[lse_pkg::CTRL_POL +: 2]);
          next_st.first = i_wdata[lse_pkg::CTRL_FIRST +: lse_pkg::IDX_W];
          next_st.last  = i_wdata[lse_pkg::CTRL_LAST +: lse_pkg::IDX_W];
        end
        lse_pkg::OFF_IRQ_STAT: irq_clr = i_wdata[lse_pkg::IRQ_W-1:0];
        lse_pkg::OFF_IRQ_MASK: begin
          next_st.irq_mask = i_wdata[lse_pkg::IRQ_W-1:0];
        end
        lse_pkg::OFF_FRM_UPD: pend_set = i_wdata[lse_pkg::NUM_FRM-1:0];
        lse_pkg::OFF_ENT_SEL: next_st.sel = i_wdata[lse_pkg::IDX_W-1:0];
        lse_pkg::OFF_ENT_CFG: begin
          next_st.ent[st.sel].cfg = lse_pkg::lse_ent_cfg_t'(i_wdata[23:0]);
        end
        lse_pkg::OFF_ENT_DLY: begin
          next_st.ent[st.sel].delay = i_wdata[lse_pkg::DLY_W-1:0];
        end
        lse_pkg::OFF_RAW_LO: begin
          next_st.ent[st.sel].node_cfg_raw_bytes[31:0] = i_wdata;
        end
        lse_pkg::OFF_RAW_HI: begin
          next_st.ent[st.sel].node_cfg_raw_bytes[63:32] = i_wdata;
        end
        lse_pkg::OFF_FRM_ID_LO: begin
          for (int k = 0; k < 4; k++) begin
            next_st.frm_id[k] = i_wdata[6*k +: 6];
          end
        end
        lse_pkg::OFF_FRM_ID_HI: begin
          for (int k = 0; k < 4; k++) begin
            next_st.frm_id[k+4] = i_wdata[6*k +: 6];
          end
        end
        default: ;
      endcase
    end

    // register reads, answered next cycle
    if (i_rd) begin
      unique case (i_addr)
        lse_pkg::OFF_CTRL: begin
          next_st.rdata = {20'h0, st.last, st.first, 1'b0,
                           st.table_run_policy, st.run};
        end
        lse_pkg::OFF_STATUS: begin
          next_st.rdata = {24'h0, st.fsm != lse_pkg::FSM_IDLE, st.in_res,
                           2'h0, st.cur};
        end
        lse_pkg::OFF_IRQ_STAT: next_st.rdata = {29'h0, st.irq_stat};
        lse_pkg::OFF_IRQ_MASK: next_st.rdata = {29'h0, st.irq_mask};
        lse_pkg::OFF_FRM_UPD:  next_st.rdata = {24'h0, st.pend};
        lse_pkg::OFF_ENT_SEL:  next_st.rdata = {28'h0, st.sel};
        lse_pkg::OFF_ENT_CFG:  next_st.rdata = {8'h0, st.ent[st.sel].cfg};
        lse_pkg::OFF_ENT_DLY:  next_st.rdata = {12'h0, st.ent[st.sel].delay};
        lse_pkg::OFF_RAW_LO: begin
          next_st.rdata = st.ent[st.sel].node_cfg_raw_bytes[31:0];
        end
        lse_pkg::OFF_RAW_HI: begin
          next_st.rdata = st.ent[st.sel].node_cfg_raw_bytes[63:32];
        end
        lse_pkg::OFF_FRM_ID_LO: begin
          next_st.rdata = {8'h0, st.frm_id[3], st.frm_id[2],
                           st.frm_id[1], st.frm_id[0]};
        end
        lse_pkg::OFF_FRM_ID_HI: begin
          next_st.rdata = {8'h0, st.frm_id[7], st.frm_id[6],
                           st.frm_id[5], st.frm_id[4]};
        end
        default: next_st.rdata = '0;
      endcase
    end

    // slot sequencer
    unique case (st.fsm)
      lse_pkg::FSM_IDLE: begin
        if (st.run && st.table_run_policy != lse_pkg::POL_NULL) begin
          next_st.cur    = st.first;
          next_st.in_res = 1'b0;
          next_st.fsm    = lse_pkg::FSM_START;
        end
      end
      lse_pkg::FSM_START: begin
        next_st.coll_seen = 1'b0;
        next_st.hdr_kind  = ent.cfg.kind;
        next_st.fsm       = lse_pkg::FSM_WAIT;
        unique case (ent.cfg.kind)
          lse_pkg::KIND_UNCOND: begin
            // shared frame pool, looked up by index
            next_st.hdr_req  = 1'b1;
            next_st.tx_frame = unc_pick;
            next_st.hdr_id   = st.frm_id[unc_pick];
          end
          lse_pkg::KIND_SPORADIC: begin
            if (spor_hit != '0) begin
              next_st.hdr_req  = 1'b1;
              next_st.tx_frame = spor_pick;
              next_st.hdr_id   = st.frm_id[spor_pick];
              pend_clr[spor_pick] = 1'b1;
              irq_ev[lse_pkg::IRQ_SPOR] = 1'b1;
            end
          end
          lse_pkg::KIND_EVENT: begin
            next_st.hdr_req = 1'b1;
            next_st.hdr_id  = ent.cfg.event_entry_identifier;
          end
          lse_pkg::KIND_NODE_CFG: begin
            next_st.hdr_req = 1'b1;
            next_st.tx_data = ent.node_cfg_raw_bytes;
          end
        endcase
      end
      lse_pkg::FSM_WAIT: begin
        next_st.coll_seen = coll_now;
        if (!st.run || st.table_run_policy == lse_pkg::POL_NULL) begin
          next_st.fsm = lse_pkg::FSM_IDLE;
        end else if (tmr_bus.expire) begin
          next_st.fsm = lse_pkg::FSM_START;
          if (coll_now) begin
            // switch to the resolving table for one pass
            next_st.ret_idx = st.cur;
            next_st.in_res  = 1'b1;
            next_st.cur     = ent.cfg.res_first;
            next_st.res_end = ent.cfg.res_last;
            next_st.res_req = 1'b1;
            irq_ev[lse_pkg::IRQ_COLL] = 1'b1;
          end else if (st.in_res) begin
            if (st.cur == st.res_end) begin
              next_st.in_res = 1'b0;
              next_st.cur    = st.ret_idx;
            end else begin
              next_st.cur = st.cur + 4'h1;
            end
          end else if (st.cur == st.last) begin
            if (st.table_run_policy == lse_pkg::POL_CONT) begin
              next_st.cur = st.first;
            end else begin
              next_st.run = 1'b0;
              next_st.fsm = lse_pkg::FSM_IDLE;
              irq_ev[lse_pkg::IRQ_DONE] = 1'b1;
            end
          end else begin
            next_st.cur = st.cur + 4'h1;
          end
        end
      end
      default: next_st.fsm = lse_pkg::FSM_IDLE;
    endcase

    // sticky flags, set wins over clear
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;
    next_st.pend     = (st.pend & ~pend_clr) | pend_set;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st          <= '0;
      st.fsm      <= lse_pkg::FSM_IDLE;
      st.irq_mask <= lse_pkg::MASK_RST;
      for (int e = 0; e < lse_pkg::NUM_ENT; e++) begin
        st.ent[e].delay <= lse_pkg::DLY_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata    = st.rdata;
  assign o_hdr_req  = st.hdr_req;
  assign o_hdr_kind = st.hdr_kind;
  assign o_hdr_id   = st.hdr_id;
  assign o_tx_frame = st.tx_frame;
  assign o_tx_data  = st.tx_data;
  assign o_res_req  = st.res_req;
  assign o_irq      = st.irq;

  // checks
  logic [lse_pkg::IDX_W-1:0] res_first_c;
  assign res_first_c = ent.cfg.res_first;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_uncond_one_frame: assert property (
    (at_start && ent.cfg.kind == lse_pkg::KIND_UNCOND)
    |=> o_hdr_req && o_tx_frame == $past(unc_pick))
    else $error("unconditional entry did not send its frame");
  chk_spor_silent: assert property (
    (at_start && ent.cfg.kind == lse_pkg::KIND_SPORADIC && spor_hit == '0)
    |=> !o_hdr_req)
    else $error("sporadic entry sent without update");
  chk_spor_first_wins: assert property (
    (at_start && ent.cfg.kind == lse_pkg::KIND_SPORADIC && spor_hit != '0)
    |=> o_hdr_req && o_tx_frame == $past(spor_pick))
    else $error("sporadic priority wrong");
  chk_spor_keep_pending: assert property (
    (at_start && ent.cfg.kind == lse_pkg::KIND_SPORADIC && spor_hit != '0)
    |=> ($past(st.pend) & ~st.pend & ~(8'h01 << $past(spor_pick))) == '0)
    else $error("unsent sporadic frame lost");
  chk_coll_switch: assert property (
    (slot_end && coll_now && st.run
     && st.table_run_policy != lse_pkg::POL_NULL)
    |=> o_res_req && st.in_res && st.cur == $past(res_first_c)
        && at_start)
    else $error("collision did not start resolving table");
  chk_res_resume: assert property (
    (slot_end && st.in_res && !coll_now && st.cur == st.res_end && st.run
     && st.table_run_policy != lse_pkg::POL_NULL)
    |=> !st.in_res && st.cur == $past(st.ret_idx))
    else $error("schedule not resumed at collision entry");
  chk_cont_wrap: assert property (
    (slot_end && !coll_now && !st.in_res && st.cur == st.last && st.run
     && st.table_run_policy == lse_pkg::POL_CONT)
    |=> st.cur == $past(st.first) ##1 o_hdr_kind == $past(ent.cfg.kind))
    else $error("continuous table did not wrap");
  chk_cfg_bytes: assert property (
    (at_start && ent.cfg.kind == lse_pkg::KIND_NODE_CFG)
    |=> o_hdr_req && o_hdr_kind == lse_pkg::KIND_NODE_CFG
        && o_tx_data == $past(ent.node_cfg_raw_bytes))
    else $error("node configuration bytes not sent");
  chk_event_ident: assert property (
    (at_start && ent.cfg.kind == lse_pkg::KIND_EVENT)
    |=> o_hdr_req && o_hdr_id == $past(ent.cfg.event_entry_identifier))
    else $error("event slot identifier wrong");

endmodule // lse_sched_exec

/* File: hw/lse_slot_timer.sv */
// slot duration down-counter
`timescale 1ns/1ns
module lse_slot_timer (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  // control
  lse_tmr_if.tmr    tmr
);

  lse_pkg::lse_tmr_st_t st;
  lse_pkg::lse_tmr_st_t next_st;

  always_comb begin
    next_st = st;
    if (tmr.load) begin
      next_st.cnt = (tmr.value == '0) ? 20'h00001 : tmr.value;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 20'h00001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tmr.expire = (st.cnt == 20'h00001) && !tmr.load;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_tmr_count_down: assert property (
    (st.cnt > 20'h00001 && !tmr.load) |=> st.cnt == $past(st.cnt) - 20'h1)
    else $error("slot timer did not count down");
  chk_tmr_load_val: assert property (
    (tmr.load && tmr.value > 20'h0) |=> st.cnt == $past(tmr.value))
    else $error("slot timer load value lost");

endmodule // lse_slot_timer

/* File: hw/lse_tmr_if.sv */
// slot timer carrier between sequencer and timer
`timescale 1ns/1ns
interface lse_tmr_if;
  logic                       load;
  logic [lse_pkg::DLY_W-1:0]  value;
  logic                       expire;
  modport ctl (output load, output value, input expire);
  modport tmr (input load, input value, output expire);
endinterface
